// file: urxpe_consts.vh
// Constants for the receive-side cell bus port enable registers.
// Assumes byte-wide direct-access host port with 10-bit addresses.
`ifndef URXPE_CONSTS_VH
`define URXPE_CONSTS_VH

// -----------------------------------------------------------------
// register offsets (direct access byte addresses)
// -----------------------------------------------------------------
`define URXPE_OFS_LINK_EN       10'h04C
`define URXPE_OFS_GROUP_EN      10'h04D
`define URXPE_OFS_GROUP_OVF_EN  10'h205
`define URXPE_OFS_LINK_OVF_EN   10'h221

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define URXPE_RST_LINK_EN       8'h00
`define URXPE_RST_GROUP_EN      7'h00
`define URXPE_RST_GROUP_OVF_EN  4'h0
`define URXPE_RST_LINK_OVF_EN   8'h00

// -----------------------------------------------------------------
// group enable register fields
// -----------------------------------------------------------------
`define URXPE_GEN_WATCH_BIT     7
`define URXPE_GEN_RSV6_BIT      6
`define URXPE_GEN_SMRST_BIT     5
`define URXPE_GEN_RSV4_BIT      4
`define URXPE_GEN_GROUP_MSB     3

// -----------------------------------------------------------------
// sizes and timing
// -----------------------------------------------------------------
`define URXPE_NUM_LINKS         8
`define URXPE_NUM_GROUPS        4
`define URXPE_PORT_ADDR_W       5
`define URXPE_CLK_PERIOD_NS     100
`define URXPE_CLK_LOSS_NS       4000
`define URXPE_CLK_LOSS_CYC      ((`URXPE_CLK_LOSS_NS + `URXPE_CLK_PERIOD_NS - 1) / `URXPE_CLK_PERIOD_NS)

`endif

// file: urxpe_sync.v
// Two-stage level synchroniser, one per bit.
// Assumes inputs are levels from another clock domain or a pin.
`timescale 1ns/100ps
`default_nettype none

module urxpe_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule
`default_nettype wire

// file: urxpe_match.v
// Port address comparator for links and groups.
// Assumes address and enable inputs are stable in the clk_sys domain.
`timescale 1ns/100ps
`default_nettype none

module urxpe_match #(
  parameter NL = 8,
  parameter NG = 4,
  parameter AW = 5
) (
  input  wire [AW-1:0]    busAddr,
  input  wire [NL*AW-1:0] linkAddrs,
  input  wire [NL-1:0]    linkEn,
  input  wire [NG*AW-1:0] groupAddrs,
  input  wire [NG-1:0]    groupEn,
  output wire [NL-1:0]    linkHit,
  output wire [NG-1:0]    groupHit
);

  genvar i;

  // a link answers only while its enable bit is set
  generate
    for (i = 0; i < NL; i = i + 1) begin : gLink
      assign linkHit[i] = linkEn[i] & (linkAddrs[i*AW +: AW] == busAddr);
    end
    for (i = 0; i < NG; i = i + 1) begin : gGroup
      assign groupHit[i] = groupEn[i] & (groupAddrs[i*AW +: AW] == busAddr);
    end
  endgenerate

endmodule
`default_nettype wire

// file: urxpe_regs.v
// Receive cell bus port enable registers and port select logic.
// Assumes a byte host port on clk_sys; bus clock and address arrive on pins.
// Notes on behaviour
// - link enable bit n makes link n answer its address in UNI mode.
// - group enable bits 3..0 make each group answer its programmed address.
// - group enable bit 7 reads the live receive bus clock level; read-only.
// - group enable bit 5 set holds receive bus state machines in reset.
// - group mask bits 3..0 let group overflow status raise interrupt.
// - link mask bits 7..0 let link overflow status raise interrupt.
// - a cleared mask bit blocks interrupt; status may still be set.
// - group mask bits 7..4 read zero and ignore writes.
// - each link has a 5-bit port address taken from the linkPortAddr input.
// - each group has its own 5-bit port address on the groupPortAddr input.
`timescale 1ns/100ps
`default_nettype none
`include "urxpe_consts.vh"

module urxpe_regs #(
  parameter NUM_LINKS   = `URXPE_NUM_LINKS,
  parameter NUM_GROUPS  = `URXPE_NUM_GROUPS,
  parameter ADDR_W      = `URXPE_PORT_ADDR_W,
  parameter LOSS_CYCLES = `URXPE_CLK_LOSS_CYC
) (
  input  wire                     clk_sys,
  input  wire                     resetn,
  input  wire [9:0]               hostAddr,
  input  wire [7:0]               hostWrData,
  input  wire                     hostWrEn,
  input  wire                     hostRdEn,
  output wire [7:0]               hostRdData,
  output wire                     hostRdValid,
  input  wire                     rxBusClk,
  input  wire [ADDR_W-1:0]        rxBusAddr,
  input  wire [NUM_LINKS*ADDR_W-1:0]  linkPortAddr,
  input  wire [NUM_GROUPS*ADDR_W-1:0] groupPortAddr,
  input  wire [NUM_GROUPS-1:0]    groupOvfStatus,
  input  wire [NUM_LINKS-1:0]     linkOvfStatus,
  output wire [NUM_LINKS-1:0]     linkPortSel,
  output wire [NUM_GROUPS-1:0]    groupPortSel,
  output wire                     portSelValid,
  output wire                     rxSmReset,
  output wire                     rxClkLost,
  output wire                     irqReq
);

  // ---------------------------------------------------------------
  // bus state machine states
  // ---------------------------------------------------------------
  localparam [1:0] ST_RESET = 2'b00;
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_MATCH = 2'b10;

  localparam [7:0] LOSS_MAX = LOSS_CYCLES[7:0];

  // ---------------------------------------------------------------
  // registers and wires
  // ---------------------------------------------------------------
  reg  [NUM_LINKS-1:0]  linkEn_q;
  reg  [6:0]            groupEnCfg_q;
  reg  [3:0]            groupOvfMask_q;
  reg  [NUM_LINKS-1:0]  linkOvfMask_q;
  reg  [7:0]            rdData_q;
  reg  [7:0]            rdData_d;
  reg                   rdValid_q;
  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg  [ADDR_W-1:0]     busAddr_q;
  reg  [NUM_LINKS-1:0]  linkSel_q;
  reg  [NUM_GROUPS-1:0] groupSel_q;
  reg                   selValid_q;
  reg                   smReset_q;
  reg                   clkPrev_q;
  reg  [7:0]            lossCnt_q;
  reg                   clkLost_q;
  reg                   irq_q;
  wire                  clkSync;
  wire [ADDR_W-1:0]     addrSync;
  wire                  clkRise;
  wire                  clkEdge;
  wire [NUM_LINKS-1:0]  linkHit;
  wire [NUM_GROUPS-1:0] groupHit;
  wire                  wrLinkEn;
  wire                  wrGroupEn;
  wire                  wrGroupMask;
  wire                  wrLinkMask;
  wire                  irqAny;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // bus clock and address are both pins; two flops each before use
  urxpe_sync #(
    .W (1 + ADDR_W)
  ) uSync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .asyncIn ({rxBusClk, rxBusAddr}),
    .syncOut ({clkSync, addrSync})
  );

  // edge finder works on the synchronised copy only
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= clkSync;
    end
  end

  assign clkRise = clkSync & ~clkPrev_q;
  assign clkEdge = clkSync ^ clkPrev_q;

  // ---------------------------------------------------------------
  // host write decode
  // ---------------------------------------------------------------
  assign wrLinkEn    = hostWrEn & (hostAddr == `URXPE_OFS_LINK_EN);
  assign wrGroupEn   = hostWrEn & (hostAddr == `URXPE_OFS_GROUP_EN);
  assign wrGroupMask = hostWrEn & (hostAddr == `URXPE_OFS_GROUP_OVF_EN);
  assign wrLinkMask  = hostWrEn & (hostAddr == `URXPE_OFS_LINK_OVF_EN);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      linkEn_q <= `URXPE_RST_LINK_EN;
    end else if (wrLinkEn) begin
      linkEn_q <= hostWrData[NUM_LINKS-1:0];
    end
  end

  // group enable store
  // bits 6 and 4 are kept as written so software sees its own value
  // reserved bits stored
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      groupEnCfg_q <= `URXPE_RST_GROUP_EN;
    end else if (wrGroupEn) begin
      groupEnCfg_q <= hostWrData[6:0];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      groupOvfMask_q <= `URXPE_RST_GROUP_OVF_EN;
    end else if (wrGroupMask) begin
      groupOvfMask_q <= hostWrData[`URXPE_GEN_GROUP_MSB:0];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      linkOvfMask_q <= `URXPE_RST_LINK_OVF_EN;
    end else if (wrLinkMask) begin
      linkOvfMask_q <= hostWrData[NUM_LINKS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // host read path
  // ---------------------------------------------------------------
  // unmapped offsets read as zero
  always @* begin
    rdData_d = 8'h00;
    case (hostAddr)
      `URXPE_OFS_LINK_EN: begin
        rdData_d = linkEn_q;
      end
      `URXPE_OFS_GROUP_EN: begin
        rdData_d = {clkSync, groupEnCfg_q};
      end
      `URXPE_OFS_GROUP_OVF_EN: begin
        rdData_d = {4'h0, groupOvfMask_q};
      end
      `URXPE_OFS_LINK_OVF_EN: begin
        rdData_d = linkOvfMask_q;
      end
      default: begin
        rdData_d = 8'h00;
      end
    endcase
  end

  // data held until the next read; valid is the read strobe delayed one cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= hostRdEn;
      if (hostRdEn) begin
        rdData_q <= rdData_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive bus state machine
  // ---------------------------------------------------------------
  // address compare
  urxpe_match #(
    .NL (NUM_LINKS),
    .NG (NUM_GROUPS),
    .AW (ADDR_W)
  ) uMatch (
    .busAddr    (busAddr_q),
    .linkAddrs  (linkPortAddr),
    .linkEn     (linkEn_q),
    .groupAddrs (groupPortAddr),
    .groupEn    (groupEnCfg_q[`URXPE_GEN_GROUP_MSB:0]),
    .linkHit    (linkHit),
    .groupHit   (groupHit)
  );

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      smReset_q <= 1'b0;
    end else begin
      smReset_q <= groupEnCfg_q[`URXPE_GEN_SMRST_BIT];
    end
  end

  // next state: sample on a bus clock rise, compare one cycle later
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (clkRise) begin
          state_d = ST_MATCH;
        end
      end
      ST_MATCH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (groupEnCfg_q[`URXPE_GEN_SMRST_BIT]) begin
      state_d = ST_RESET;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // address captured on the rise; selection updated in the match state
  // select update
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busAddr_q  <= {ADDR_W{1'b0}};
      linkSel_q  <= {NUM_LINKS{1'b0}};
      groupSel_q <= {NUM_GROUPS{1'b0}};
      selValid_q <= 1'b0;
    end else if (state_q == ST_RESET) begin
      linkSel_q  <= {NUM_LINKS{1'b0}};
      groupSel_q <= {NUM_GROUPS{1'b0}};
      selValid_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && clkRise) begin
        busAddr_q <= addrSync;
      end
      if (state_q == ST_MATCH) begin
        linkSel_q  <= linkHit;
        groupSel_q <= groupHit;
        selValid_q <= (|linkHit) | (|groupHit);
      end
    end
  end

  // ---------------------------------------------------------------
  // bus clock activity watch
  // ---------------------------------------------------------------
  // register reads of the clock bit are only meaningful with a live clock,
  // so a silent clock is flagged; it does not block host access
  // clock loss flag
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lossCnt_q <= 8'h00;
      clkLost_q <= 1'b0;
    end else if (clkEdge) begin
      lossCnt_q <= 8'h00;
      clkLost_q <= 1'b0;
    end else if (lossCnt_q >= LOSS_MAX) begin
      clkLost_q <= 1'b1;
    end else begin
      lossCnt_q <= lossCnt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // status is only masked here; it is never altered
  // masked overflow
  assign irqAny = (|(groupOvfStatus & groupOvfMask_q)) | (|(linkOvfStatus & linkOvfMask_q));

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irqAny;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hostRdData   = rdData_q;
  assign hostRdValid  = rdValid_q;
  assign linkPortSel  = linkSel_q;
  assign groupPortSel = groupSel_q;
  assign portSelValid = selValid_q;
  assign rxSmReset    = smReset_q;
  assign rxClkLost    = clkLost_q;
  assign irqReq       = irq_q;

endmodule
`default_nettype wire

// file: urxpe_regs_end.v
`timescale 1ns/100ps

// file: urxpe_regs_chk.sv
// port checker for the receive port enable registers
// assumes binding to urxpe_regs; sees only its ports
`timescale 1ns/100ps
`default_nettype none
module urxpe_regs_chk #(
  parameter NUM_LINKS  = 8,
  parameter NUM_GROUPS = 4
) (
  input wire logic                  clk_sys,
  input wire logic                  resetn,
  input wire logic [9:0]            hostAddr,
  input wire logic [7:0]            hostWrData,
  input wire logic                  hostWrEn,
  input wire logic                  hostRdEn,
  input wire logic [7:0]            hostRdData,
  input wire logic                  hostRdValid,
  input wire logic                  rxBusClk,
  input wire logic [NUM_GROUPS-1:0] groupOvfStatus,
  input wire logic [NUM_LINKS-1:0]  linkOvfStatus,
  input wire logic [NUM_LINKS-1:0]  linkPortSel,
  input wire logic [NUM_GROUPS-1:0] groupPortSel,
  input wire logic                  portSelValid,
  input wire logic                  rxSmReset,
  input wire logic                  rxClkLost,
  input wire logic                  irqReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // host port and register fields
  // ----------------------------------------
  rd_pulse_a:
    assert property (hostRdValid == $past(hostRdEn)) else $error("read valid misplaced");
  watch_clk_a:
    assert property (hostRdEn && hostAddr == 10'h04D |=> hostRdData[7] == $past(rxBusClk, 3)
      || hostRdData[7] == $past(rxBusClk, 2)) else $error("watch bit wrong");
  mask_high_a:
    assert property (hostRdEn && hostAddr == 10'h205 |=> hostRdData[7:4] == 4'h0) else $error("mask top set");
  smrst_set_a:
    assert property (hostWrEn && hostAddr == 10'h04D && hostWrData[5] |-> ##[1:2] rxSmReset)
      else $error("bus reset not raised");
  sel_held_a:
    assert property (rxSmReset && $past(rxSmReset) |-> linkPortSel == '0 && groupPortSel == '0)
      else $error("select during reset");
  sel_valid_a:
    assert property (portSelValid == (|linkPortSel || |groupPortSel)) else $error("valid mismatch");
  // ----------------------------------------
  // interrupt and clock watch
  // ----------------------------------------
  irq_quiet_a:
    assert property (linkOvfStatus == '0 && groupOvfStatus == '0 |=> !irqReq) else $error("spurious irq");
  irq_link_a:
    assert property (hostWrEn && hostAddr == 10'h221 && |(hostWrData & linkOvfStatus)
      ##1 $stable(linkOvfStatus) |=> irqReq) else $error("link irq missing");
  irq_group_a:
    assert property (hostWrEn && hostAddr == 10'h205 && |(hostWrData[3:0] & groupOvfStatus)
      ##1 $stable(groupOvfStatus) |=> irqReq) else $error("group irq missing");
  clk_seen_a:
    assert property ($rose(rxBusClk) |-> ##[1:6] !rxClkLost) else $error("clock loss stuck");
  cover property ($rose(portSelValid));
  cover property ($rose(irqReq));
  cover property ($rose(rxClkLost));
endmodule
bind urxpe_regs urxpe_regs_chk #(.NUM_LINKS(NUM_LINKS), .NUM_GROUPS(NUM_GROUPS)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
  .rxBusClk(rxBusClk), .groupOvfStatus(groupOvfStatus), .linkOvfStatus(linkOvfStatus),
  .linkPortSel(linkPortSel), .groupPortSel(groupPortSel), .portSelValid(portSelValid),
  .rxSmReset(rxSmReset), .rxClkLost(rxClkLost), .irqReq(irqReq));
`default_nettype wire

// file: urxpe_bus_master.sv
// cell bus master model: bus clock and port address
// assumes nothing of clk_sys; phase is unrelated on purpose
`timescale 1ns/100ps
`default_nettype none
module urxpe_bus_master (
  input  wire logic       run,
  input  wire logic [4:0] addrIn,
  output var  logic       rxBusClk,
  output var  logic [4:0] rxBusAddr
);
  // clock toggles
  // one process drives both pins so neither has a second driver
  initial begin
    rxBusClk = 1'b0;
    rxBusAddr = 5'h00;
    #37;
    forever begin
      #400;
      if (run) begin
        rxBusClk = ~rxBusClk; // parks at its level when stopped
        // address moves on the fall, half a period clear of the rise
        if (!rxBusClk) rxBusAddr = addrIn;
      end
    end
  end
endmodule
`default_nettype wire

// file: urxpe_regs_tb.sv
// testbench for the receive port enable registers
// assumes urxpe_regs, its checker and the bus master model
`timescale 1ns/100ps
`default_nettype none
module urxpe_regs_tb;
  logic        clk_sys, resetn, hostWrEn, hostRdEn, run, portSelValid;
  logic        hostRdValid, rxBusClk, rxSmReset, rxClkLost, irqReq;
  logic [9:0]  hostAddr;
  logic [7:0]  hostWrData, hostRdData, linkOvfStatus, linkPortSel;
  logic [4:0]  busAddr, rxBusAddr;
  logic [39:0] linkPortAddr;
  logic [19:0] groupPortAddr;
  logic [3:0]  groupOvfStatus, groupPortSel;
  int          errCount, testsRun, cycles;
  urxpe_regs #(.LOSS_CYCLES(40)) dut (.clk_sys(clk_sys), .resetn(resetn), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .rxBusClk(rxBusClk), .rxBusAddr(rxBusAddr), .linkPortAddr(linkPortAddr),
    .groupPortAddr(groupPortAddr), .groupOvfStatus(groupOvfStatus), .linkOvfStatus(linkOvfStatus),
    .linkPortSel(linkPortSel), .groupPortSel(groupPortSel), .portSelValid(portSelValid),
    .rxSmReset(rxSmReset), .rxClkLost(rxClkLost), .irqReq(irqReq));
  urxpe_bus_master master (.run(run), .addrIn(busAddr), .rxBusClk(rxBusClk), .rxBusAddr(rxBusAddr));
  // ----------------------------------------
  // clock, timeout and common tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // a hang costs a mismatch rather than a silent stall
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // tasks start and end at a falling edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    hostAddr = a;
    hostWrData = d;
    hostWrEn = 1'b1;
    cyc(1);
    hostWrEn = 1'b0;
    cyc(1); // strobe low for one edge before the next request
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] m);
    hostAddr = a;
    hostRdEn = 1'b1;
    cyc(1);
    hostRdEn = 1'b0;
    chk({7'h00, hostRdValid}, 8'h01, "rvalid");
    chk(hostRdData & m, exp, "rdata");
    cyc(1); // strobe low for one edge before the next request
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(10'h04C, 8'h00, 8'hFF);
    rd(10'h04D, 8'h00, 8'h7F);
    rd(10'h205, 8'h00, 8'hFF);
    rd(10'h221, 8'h00, 8'hFF);
    wr(10'h04C, 8'hA5);
    rd(10'h04C, 8'hA5, 8'hFF);
    wr(10'h205, 8'hF6);
    rd(10'h205, 8'h06, 8'hFF);
    wr(10'h221, 8'h5A);
    rd(10'h221, 8'h5A, 8'hFF);
    wr(10'h04D, 8'h80);
    rd(10'h04D, 8'h00, 8'h7F);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00, 8'hFF);
  endtask
  task automatic t_watch;
    @(posedge rxBusClk);
    run = 1'b0;
    cyc(6);
    rd(10'h04D, 8'h80, 8'h80);
    cyc(50);
    chk({7'h00, rxClkLost}, 8'h01, "lost");
    run = 1'b1;
    @(negedge rxBusClk);
    run = 1'b0;
    cyc(6);
    rd(10'h04D, 8'h00, 8'h80);
    run = 1'b1;
    cyc(20);
    chk({7'h00, rxClkLost}, 8'h00, "alive");
  endtask
  // links answer 8..15, groups 24..27; reserved bits stay zero
  task automatic t_sel(input logic [7:0] le, input logic [3:0] ge);
    wr(10'h04C, le);
    wr(10'h04D, {4'h0, ge});
    for (int i = 0; i < 12; i++) begin
      busAddr = (i < 8) ? 5'(i + 8) : 5'(i + 16);
      cyc(20);
      chk(linkPortSel, (i < 8) ? le & (8'h01 << i) : 8'h00, "link");
      chk({4'h0, groupPortSel}, (i < 8) ? 8'h00 : {4'h0, ge} & (8'h01 << (i - 8)), "group");
      chk({7'h00, portSelValid}, {7'h00, (i < 8) ? le[i] : ge[i - 8]}, "valid");
    end
  endtask
  task automatic t_smrst;
    wr(10'h04D, 8'h2A);
    cyc(20);
    chk({7'h00, rxSmReset}, 8'h01, "smrst");
    chk({4'h0, groupPortSel}, 8'h00, "held");
    rd(10'h04D, 8'h2A, 8'h7F);
    wr(10'h04D, 8'h0A);
    cyc(20);
    chk({4'h0, groupPortSel}, 8'h08, "resume");
  endtask
  task automatic t_irq;
    wr(10'h205, 8'h00);
    wr(10'h221, 8'h00);
    linkOvfStatus = 8'hFF;
    groupOvfStatus = 4'hF;
    cyc(3);
    chk({7'h00, irqReq}, 8'h00, "masked");
    wr(10'h221, 8'h10);
    cyc(2);
    chk({7'h00, irqReq}, 8'h01, "link");
    linkOvfStatus = 8'hEF;
    cyc(3);
    chk({7'h00, irqReq}, 8'h00, "other");
    wr(10'h221, 8'h00);
    wr(10'h205, 8'h08);
    cyc(2);
    chk({7'h00, irqReq}, 8'h01, "group");
    groupOvfStatus = 4'h7;
    cyc(3);
    chk({7'h00, irqReq}, 8'h00, "gother");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, hostWrEn, hostRdEn, hostAddr, hostWrData} = '0;
    {linkOvfStatus, groupOvfStatus, busAddr} = '0;
    run = 1'b1;
    for (int i = 0; i < 8; i++) linkPortAddr[i*5 +: 5] = 5'(i + 8);
    for (int i = 0; i < 4; i++) groupPortAddr[i*5 +: 5] = 5'(i + 24);
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    t_regs();
    t_watch();
    t_sel(8'hA5, 4'h5);
    t_sel(8'h5A, 4'hA);
    t_smrst();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
